// *** rtl/trc_defs.vh ***
// Constants for the tone and ringing oscillator control register bank
`ifndef TRC_DEFS_VH
`define TRC_DEFS_VH

// Register indices; byte address is four times the index
`define TRC_IDX_PENDING     6'h1F
`define TRC_IDX_TONE_A      6'h20
`define TRC_IDX_TONE_B      6'h21
`define TRC_IDX_RING        6'h22

// Reset values
`define TRC_RST_TONE_A      7'h00
`define TRC_RST_TONE_B      6'h00
`define TRC_RST_RING        4'h0

// Field positions in the tone control registers
`define TRC_TN_ACTIVE       7
`define TRC_TN_RELOAD       6
`define TRC_TN_ZC           5
`define TRC_TN_ON_EN        4
`define TRC_TN_OFF_EN       3
`define TRC_TN_ENABLE       2
`define TRC_TN_ROUTE_HI     1
`define TRC_TN_ROUTE_LO     0

// Field positions in the ringing control register
`define TRC_RG_ACTIVE       7
`define TRC_RG_ON_LINE      5
`define TRC_RG_ON_EN        4
`define TRC_RG_OFF_EN       3
`define TRC_RG_ENABLE       2
`define TRC_RG_DC_OFFSET    1
`define TRC_RG_WAVE         0

// Field position in the indirect status register
`define TRC_IP_PENDING      0

// Indirect memory update rate
`define TRC_CLK_HZ          50000000
`define TRC_UPD_HZ          16000
`define TRC_UPD_CYCLES      (`TRC_CLK_HZ / `TRC_UPD_HZ)

`endif

// *** rtl/trc_ctrl.v ***
// Tone and ringing oscillator control registers with cadence sequencing
`timescale 1ns/100ps
`default_nettype none
`include "trc_defs.vh"

module trc_ctrl (
  input  wire        i_clock,
  input  wire        i_nrst,
  input  wire        i_clk_en,
  // Avalon-MM slave, byte addressed
  input  wire [7:0]  i_avs_address,
  input  wire        i_avs_read,
  input  wire        i_avs_write,
  input  wire [31:0] i_avs_writedata,
  input  wire [3:0]  i_avs_byteenable,
  output wire [31:0] o_avs_readdata,
  output wire        o_avs_waitrequest,
  // Indirect access
  input  wire        i_indirect_req,
  output wire        o_indirect_update,
  // Tone A
  input  wire        i_tone_a_on_expire,
  input  wire        i_tone_a_off_expire,
  input  wire        i_tone_a_zero_cross,
  output wire        o_tone_a_run,
  output wire        o_tone_a_tx,
  output wire        o_tone_a_rx,
  output wire        o_tone_a_on_timer_run,
  output wire        o_tone_a_off_timer_run,
  output wire        o_tone_a_reload,
  // Tone B
  input  wire        i_tone_b_on_expire,
  input  wire        i_tone_b_off_expire,
  input  wire        i_tone_b_zero_cross,
  output wire        o_tone_b_run,
  output wire        o_tone_b_tx,
  output wire        o_tone_b_rx,
  output wire        o_tone_b_on_timer_run,
  output wire        o_tone_b_off_timer_run,
  output wire        o_tone_b_reload,
  // Ringing
  input  wire        i_ring_osc_enable,
  input  wire        i_ring_on_expire,
  input  wire        i_ring_off_expire,
  input  wire        i_ring_dc_match,
  output wire        o_ring_run,
  output wire        o_ring_on_timer_run,
  output wire        o_ring_off_timer_run,
  output wire        o_ring_dc_offset_en,
  output wire        o_ring_wave_select,
  output wire        o_ring_drive_line
);

  // Cadence states, one-hot
  localparam [4:0] ST_IDLE  = 5'h01;
  localparam [4:0] ST_ON    = 5'h02;
  localparam [4:0] ST_ZWAIT = 5'h04;
  localparam [4:0] ST_OFF   = 5'h08;
  localparam [4:0] ST_DONE  = 5'h10;

  // Last count of the update timebase, cut to the counter width on purpose
  localparam integer UPD_LAST_I = `TRC_UPD_CYCLES - 1;
  localparam [11:0]  UPD_LAST   = UPD_LAST_I[11:0];

  // Cadence sequencer shared by all three oscillators
  function [4:0] cad_next;
    input [4:0] st;
    input       en;
    input       on_en;
    input       on_exp;
    input       off_en;
    input       off_exp;
    input       zc_en;
    input       zc;
    input       reload;
    reg         off_done;
    begin
      cad_next = st;
      off_done = ~off_en | off_exp;
      if (!en) begin
        cad_next = ST_IDLE;
      end else begin
        case (st)
          ST_IDLE: cad_next = ST_ON;
          ST_ON: begin
            if (on_en && on_exp) begin
              cad_next = zc_en ? ST_ZWAIT : ST_OFF;
            end
          end
          ST_ZWAIT: begin
            if (zc) begin
              cad_next = ST_OFF;
            end
          end
          ST_OFF: begin
            if (off_done) begin
              cad_next = reload ? ST_ON : ST_DONE;
            end
          end
          ST_DONE: cad_next = ST_DONE;
          default: cad_next = ST_IDLE;
        endcase
      end
    end
  endfunction

  // Bus state
  reg        ack_r;
  reg [31:0] rdata_r;
  wire       req      = i_avs_read | i_avs_write;
  wire       fire     = req & ack_r & i_clk_en;
  wire [5:0] idx      = i_avs_address[7:2];
  wire       wr_lane0 = fire & i_avs_write & i_avs_byteenable[0];

  // Control registers
  reg [6:0] tone_a_r;
  reg [5:0] tone_b_r;
  reg [3:0] ring_r;   // on_en, off_en, dc_offset, wave
  reg       pending_r;
  reg [11:0] upd_cnt_r;
  reg [4:0] st_a_r;
  reg [4:0] st_b_r;
  reg [4:0] st_r_r;
  reg       on_line_r;

  wire upd_tick = (upd_cnt_r == UPD_LAST);

  wire [4:0] st_a_nxt = cad_next(st_a_r,
                                 tone_a_r[`TRC_TN_ENABLE],
                                 tone_a_r[`TRC_TN_ON_EN],
                                 i_tone_a_on_expire,
                                 tone_a_r[`TRC_TN_OFF_EN],
                                 i_tone_a_off_expire,
                                 tone_a_r[`TRC_TN_ZC],
                                 i_tone_a_zero_cross,
                                 tone_a_r[`TRC_TN_RELOAD]);
  // Tone B has no reload bit and always repeats its cadence
  wire [4:0] st_b_nxt = cad_next(st_b_r,
                                 tone_b_r[`TRC_TN_ENABLE],
                                 tone_b_r[`TRC_TN_ON_EN],
                                 i_tone_b_on_expire,
                                 tone_b_r[`TRC_TN_OFF_EN],
                                 i_tone_b_off_expire,
                                 tone_b_r[`TRC_TN_ZC],
                                 i_tone_b_zero_cross,
                                 1'b1);
  // Ringing never waits for a zero crossing; the line gate does that job
  wire [4:0] st_r_nxt = cad_next(st_r_r,
                                 i_ring_osc_enable,
                                 ring_r[3],
                                 i_ring_on_expire,
                                 ring_r[2],
                                 i_ring_off_expire,
                                 1'b0,
                                 1'b0,
                                 1'b1);

  wire a_active = st_a_r[1] | st_a_r[2];
  wire b_active = st_b_r[1] | st_b_r[2];
  wire r_active = st_r_r[1] | st_r_r[2];

  // Readback, reserved bits forced to zero
  reg [7:0] rd_byte;
  always @* begin
    rd_byte = 8'h00;
    case (idx)
      `TRC_IDX_PENDING: begin
        rd_byte = {7'h00, pending_r};
      end
      `TRC_IDX_TONE_A: begin
        rd_byte = {a_active, tone_a_r};
      end
      `TRC_IDX_TONE_B: begin
        rd_byte = {b_active, 1'b0, tone_b_r};
      end
      `TRC_IDX_RING: begin
        rd_byte = {r_active, 1'b0, on_line_r, ring_r[3:2],
                   i_ring_osc_enable, ring_r[1:0]};
      end
      default: begin
        rd_byte = 8'h00;
      end
    endcase
  end

  // Bus handshake: one wait cycle, then the answer
  reg        ack_nxt;
  reg [31:0] rdata_nxt;
  always @* begin
    ack_nxt   = ack_r;
    rdata_nxt = rdata_r;
    if (i_clk_en) begin
      ack_nxt = req & ~ack_r;
      // Read data is captured in the wait cycle so it stands when the answer comes
      if (req && !ack_r) begin
        rdata_nxt = {24'h00_0000, rd_byte};
      end
    end
  end

  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      ack_r   <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      ack_r   <= ack_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign o_avs_waitrequest = req & ~(ack_r & i_clk_en);
  assign o_avs_readdata    = rdata_r;

  // Register writes; read-only bits are not stored
  reg [6:0] tone_a_nxt;
  reg [5:0] tone_b_nxt;
  reg [3:0] ring_nxt;
  always @* begin
    tone_a_nxt = tone_a_r;
    tone_b_nxt = tone_b_r;
    ring_nxt   = ring_r;
    if (wr_lane0) begin
      case (idx)
        `TRC_IDX_TONE_A: begin
          tone_a_nxt = i_avs_writedata[6:0];
        end
        `TRC_IDX_TONE_B: begin
          tone_b_nxt = i_avs_writedata[5:0];
        end
        `TRC_IDX_RING: begin
          // Bit 2 is the enable pin's mirror and bit 5 the line flag
          ring_nxt = {i_avs_writedata[4:3], i_avs_writedata[1:0]};
        end
        default: begin
          tone_a_nxt = tone_a_r;
        end
      endcase
    end
  end

  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      tone_a_r <= `TRC_RST_TONE_A;
      tone_b_r <= `TRC_RST_TONE_B;
      ring_r   <= `TRC_RST_RING;
    end else begin
      tone_a_r <= tone_a_nxt;
      tone_b_r <= tone_b_nxt;
      ring_r   <= ring_nxt;
    end
  end

  // Indirect update timebase and pending flag; a new request wins over the clear
  reg [11:0] upd_cnt_nxt;
  reg        pending_nxt;
  always @* begin
    upd_cnt_nxt = upd_cnt_r;
    pending_nxt = pending_r;
    if (i_clk_en) begin
      if (upd_tick) begin
        upd_cnt_nxt = 12'h000;
      end else begin
        upd_cnt_nxt = upd_cnt_r + 12'h001;
      end
      if (i_indirect_req) begin
        pending_nxt = 1'b1;
      end else if (upd_tick) begin
        pending_nxt = 1'b0;
      end
    end
  end

  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      upd_cnt_r <= 12'h000;
      pending_r <= 1'b0;
    end else begin
      upd_cnt_r <= upd_cnt_nxt;
      pending_r <= pending_nxt;
    end
  end

  assign o_indirect_update = upd_tick & pending_r & i_clk_en;

  // Cadence sequencers
  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      st_a_r <= ST_IDLE;
      st_b_r <= ST_IDLE;
      st_r_r <= ST_IDLE;
    end else if (i_clk_en) begin
      st_a_r <= st_a_nxt;
      st_b_r <= st_b_nxt;
      st_r_r <= st_r_nxt;
    end
  end

  // Line drive changes only when the waveform meets the dc feed level,
  // so starting or stopping never puts a step onto the line
  reg on_line_nxt;
  always @* begin
    on_line_nxt = on_line_r;
    if (i_clk_en && i_ring_dc_match) begin
      on_line_nxt = r_active;
    end
  end

  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      on_line_r <= 1'b0;
    end else begin
      on_line_r <= on_line_nxt;
    end
  end

  assign o_tone_a_run           = a_active;
  assign o_tone_a_tx            = a_active & tone_a_r[`TRC_TN_ROUTE_LO];
  assign o_tone_a_rx            = a_active & tone_a_r[`TRC_TN_ROUTE_HI];
  assign o_tone_a_on_timer_run  = st_a_r[1] & tone_a_r[`TRC_TN_ON_EN];
  assign o_tone_a_off_timer_run = st_a_r[3] & tone_a_r[`TRC_TN_OFF_EN];
  // Parameters are reloaded on every entry to the active period
  assign o_tone_a_reload        = i_clk_en & st_a_nxt[1] & ~st_a_r[1];

  assign o_tone_b_run           = b_active;
  assign o_tone_b_tx            = b_active & tone_b_r[`TRC_TN_ROUTE_LO];
  assign o_tone_b_rx            = b_active & tone_b_r[`TRC_TN_ROUTE_HI];
  assign o_tone_b_on_timer_run  = st_b_r[1] & tone_b_r[`TRC_TN_ON_EN];
  assign o_tone_b_off_timer_run = st_b_r[3] & tone_b_r[`TRC_TN_OFF_EN];
  assign o_tone_b_reload        = i_clk_en & st_b_nxt[1] & ~st_b_r[1];

  assign o_ring_run             = r_active;
  assign o_ring_on_timer_run    = st_r_r[1] & ring_r[3];
  assign o_ring_off_timer_run   = st_r_r[3] & ring_r[2];
  assign o_ring_dc_offset_en    = ring_r[1];
  assign o_ring_wave_select     = ring_r[0];
  assign o_ring_drive_line      = on_line_r;

endmodule // trc_ctrl
`default_nettype wire

// *** tb/trc_ctrl_asserts.sv ***
// Checker for the oscillator control register bank
`timescale 1ns/100ps
`default_nettype none
module trc_ctrl_asserts (
  input wire logic        i_clock,
  input wire logic        i_nrst,
  input wire logic        i_clk_en,
  input wire logic [7:0]  i_avs_address,
  input wire logic        i_avs_read,
  input wire logic [31:0] o_avs_readdata,
  input wire logic        o_avs_waitrequest,
  input wire logic        i_indirect_req,
  input wire logic        o_indirect_update,
  input wire logic        o_tone_a_run,
  input wire logic        o_tone_a_tx,
  input wire logic        o_tone_a_rx,
  input wire logic        o_tone_a_on_timer_run,
  input wire logic        o_tone_a_off_timer_run,
  input wire logic        i_ring_osc_enable,
  input wire logic        i_ring_dc_match,
  input wire logic        o_ring_run,
  input wire logic        o_ring_drive_line
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  logic [12:0] wait_r;
  // Cycles an indirect request has waited for its update
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) wait_r <= 13'h0000;
    else if (o_indirect_update) wait_r <= 13'h0000;
    else if (i_indirect_req || wait_r != 13'h0000) wait_r <= wait_r + 13'h0001;
  end
  AST_RSV_ZERO: assert property (i_avs_read && !o_avs_waitrequest |->
    o_avs_readdata[31:8] == 24'h000000 && (i_avs_address != 8'h7C || o_avs_readdata[7:1] == 7'h00))
    else $error("reserved read bits set");
  AST_ACK: assert property (i_avs_read && o_avs_waitrequest && i_clk_en |=> !o_avs_waitrequest || !i_clk_en)
    else $error("read not answered after one cycle");
  AST_ROUTE: assert property ((o_tone_a_tx || o_tone_a_rx) |-> o_tone_a_run)
    else $error("tone routed while inactive");
  AST_ON_TMR: assert property (o_tone_a_on_timer_run |-> o_tone_a_run)
    else $error("active timer outside active period");
  AST_OFF_TMR: assert property (o_tone_a_off_timer_run |-> !o_tone_a_run)
    else $error("inactive timer during active period");
  AST_RING_EN: assert property (!i_ring_osc_enable && i_clk_en |=> !o_ring_run)
    else $error("ringing active while disabled");
  AST_LINE_DC: assert property ($changed(o_ring_drive_line) |-> $past(i_ring_dc_match))
    else $error("line drive changed off the dc match");
  AST_UPD_ONE: assert property (o_indirect_update && i_clk_en |=> !o_indirect_update)
    else $error("update pulse longer than one cycle");
  AST_UPD_BOUND: assert property (wait_r <= 13'h0C37)
    else $error("indirect update late");
  cover property (o_indirect_update);
  cover property ($rose(o_ring_drive_line));
  cover property (o_tone_a_tx && o_tone_a_rx);
endmodule // trc_ctrl_asserts
bind trc_ctrl trc_ctrl_asserts trc_ctrl_asserts_i (.*);
`default_nettype wire

// *** tb/trc_ctrl_tb.sv ***
// Self-checking bench for the oscillator control register bank
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_fail++; \
  $display("mismatch t=%0t got %h exp %h", $time, (a), (e)); end end
module trc_ctrl_tb;
  logic        clk = 1'b0, nrst = 1'b0, rd = 1'b0, wr = 1'b0, ring_en = 1'b0, dcm = 1'b0, ce = 1'b1;
  logic [7:0]  ad = 8'h00, wd = 8'h00;
  logic [8:0]  ev = 9'h000;
  logic [31:0] q;
  wire  [31:0] rdata;
  wire         wt, upd, ta_run, ta_tx, ta_rx, tb_run, r_run, r_line, dco, wav;
  int          n_fail = 0;
  int          checks_done = 0;
  always #10 clk = ~clk;
  trc_ctrl trc_ctrl_i (.i_clock(clk), .i_nrst(nrst), .i_clk_en(ce), .i_avs_address(ad), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata({24'h000000, wd}), .i_avs_byteenable(4'hF), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wt), .i_indirect_req(ev[0]), .o_indirect_update(upd), .i_tone_a_on_expire(ev[1]),
    .i_tone_a_off_expire(ev[2]), .i_tone_a_zero_cross(ev[3]), .o_tone_a_run(ta_run), .o_tone_a_tx(ta_tx),
    .o_tone_a_rx(ta_rx), .o_tone_a_on_timer_run(), .o_tone_a_off_timer_run(), .o_tone_a_reload(),
    .i_tone_b_on_expire(ev[4]), .i_tone_b_off_expire(ev[5]), .i_tone_b_zero_cross(ev[6]), .o_tone_b_run(tb_run),
    .o_tone_b_tx(), .o_tone_b_rx(), .o_tone_b_on_timer_run(), .o_tone_b_off_timer_run(), .o_tone_b_reload(),
    .i_ring_osc_enable(ring_en), .i_ring_on_expire(ev[7]), .i_ring_off_expire(ev[8]), .i_ring_dc_match(dcm),
    .o_ring_run(r_run), .o_ring_on_timer_run(), .o_ring_off_timer_run(), .o_ring_dc_offset_en(dco),
    .o_ring_wave_select(wav), .o_ring_drive_line(r_line));
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // One Avalon transfer; read data lands in q
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    rd <= !w;
    wr <= w;
    ad <= a;
    wd <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wt !== 1'b0 && n < 50);
    if (wt !== 1'b0) begin
      n_fail++;
      tally_and_finish;
    end
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    `CHK(q, {24'h000000, e})
  endtask
  task automatic st;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic pulse(input int i);
    @(posedge clk);
    ev[i] <= 1'b1;
    @(posedge clk);
    ev[i] <= 1'b0;
    st;
  endtask
  task automatic wait_upd;
    for (int i = 0; i < 4000 && upd !== 1'b1; i++) @(negedge clk);
    `CHK(upd, 1'b1)
    if (upd !== 1'b1) tally_and_finish;
    st;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    rdc(8'h7C, 8'h00);
    rdc(8'h80, 8'h00);
    rdc(8'h84, 8'h00);
    rdc(8'h88, 8'h00);
    bus(1'b1, 8'h90, 8'hFF);
    rdc(8'h90, 8'h00);
    bus(1'b1, 8'h84, 8'hFF);
    rdc(8'h84, 8'hBF);
    for (int r = 0; r < 4; r++) begin
      bus(1'b1, 8'h80, 8'h04 | r[7:0]);
      st;
      `CHK({ta_run, ta_rx, ta_tx}, {1'b1, r[1:0]})
    end
    bus(1'b1, 8'h80, 8'h00);
    st;
    `CHK(ta_run, 1'b0)
    bus(1'b1, 8'h80, 8'h0F);
    pulse(1);
    rdc(8'h80, 8'h8F);
    bus(1'b1, 8'h80, 8'h00);
    bus(1'b1, 8'h80, 8'h1F);
    pulse(1);
    rdc(8'h80, 8'h1F);
    pulse(2);
    `CHK(ta_run, 1'b0)
    bus(1'b1, 8'h80, 8'h00);
    bus(1'b1, 8'h80, 8'h5C);
    pulse(1);
    pulse(2);
    `CHK(ta_run, 1'b1)
    bus(1'b1, 8'h80, 8'h00);
    bus(1'b1, 8'h80, 8'h3C);
    pulse(1);
    `CHK(ta_run, 1'b1)
    pulse(3);
    `CHK(ta_run, 1'b0)
    bus(1'b1, 8'h84, 8'h3C);
    pulse(4);
    `CHK(tb_run, 1'b1)
    pulse(6);
    `CHK(tb_run, 1'b0)
    bus(1'b1, 8'h88, 8'hFF);
    rdc(8'h88, 8'h1B);
    `CHK({dco, wav}, 2'b11)
    bus(1'b1, 8'h88, 8'h18);
    st;
    `CHK({dco, wav}, 2'b00)
    @(posedge clk);
    ring_en <= 1'b1;
    st;
    rdc(8'h88, 8'h9C);
    dcm <= 1'b1;
    st;
    rdc(8'h88, 8'hBC);
    dcm <= 1'b0;
    pulse(7);
    `CHK({r_run, r_line}, 2'b01)
    @(posedge clk);
    dcm <= 1'b1;
    pulse(8);
    `CHK(r_run, 1'b1)
    @(posedge clk);
    ring_en <= 1'b0;
    pulse(0);
    wait_upd;
    rdc(8'h7C, 8'h00);
    pulse(0);
    rdc(8'h7C, 8'h01);
    wait_upd;
    rdc(8'h7C, 8'h00);
    @(posedge clk);
    ce <= 1'b0;
    pulse(0);
    `CHK(upd, 1'b0)
    @(posedge clk);
    ce <= 1'b1;
    rdc(8'h7C, 8'h00);
    tally_and_finish;
  end
endmodule // trc_ctrl_tb
`default_nettype wire
